// [rtl/gpp_port.sv]
// One byte-wide general-purpose I/O port: registers, pin control and
// peripheral routing. Assumes the pad ring resolves pad_out/pad_oe and
// returns the real pin level on pad_in; CPU accesses are single cycle.
`timescale 1ns/1ps

module gpp_port
	import gpp_pkg::*;
#(
	parameter logic [7:0] ALT0_MASK   = GPP_DEF_ALT0_MASK,
	parameter logic [7:0] ALT1_MASK   = GPP_DEF_ALT1_MASK,
	parameter int         SYNC_DEPTH  = GPP_SYNC_STAGES,
	parameter int         DATA_W      = GPP_DATA_W
)
(
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  arst_n,

	// CPU register port
	input  wire logic [GPP_ADDR_W-1:0] cpu_addr,
	input  wire logic                  cpu_wr,
	input  wire logic                  cpu_rd,
	input  wire logic [DATA_W-1:0]     cpu_wdata,
	output logic      [DATA_W-1:0]     cpu_rdata,
	output logic                       cpu_rvalid,

	// Pad controls
	input  wire logic [DATA_W-1:0]     pad_in,
	output logic      [DATA_W-1:0]     pad_out,
	output logic      [DATA_W-1:0]     pad_oe,
	output logic      [DATA_W-1:0]     pad_pullup,
	output logic      [DATA_W-1:0]     pad_fast,

	// First peripheral function
	input  wire logic [DATA_W-1:0]     periph_a_out,
	input  wire logic [DATA_W-1:0]     periph_a_oe,
	output logic      [DATA_W-1:0]     periph_a_in,

	// Second peripheral function
	input  wire logic [DATA_W-1:0]     periph_b_out,
	input  wire logic [DATA_W-1:0]     periph_b_oe,
	output logic      [DATA_W-1:0]     periph_b_in
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// The register map and pin routing are byte wide only
	if (DATA_W != GPP_DATA_W)
	begin : g_bad_width
		$error("gpp_port: DATA_W must be 8");
	end
	// Only a two-flop synchroniser is provided
	if (SYNC_DEPTH != GPP_SYNC_STAGES)
	begin : g_bad_sync
		$error("gpp_port: SYNC_DEPTH must be 2");
	end

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0] alt_function_enable;
	logic [7:0] alt_function_choice;
	logic [7:0] pin_direction;
	logic [7:0] pullup_enable;
	logic [7:0] slew_rate_select;
	logic [7:0] output_data_latch;
	logic [7:0] pin_level_input;

	gpp_sel_t   wr_sel;
	gpp_sel_t   rd_sel;
	logic       wr_hit;

	logic [7:0] next_pad_out;
	logic [7:0] next_pad_oe;
	logic [7:0] next_pad_pullup;
	logic [7:0] next_periph_a_in;
	logic [7:0] next_periph_b_in;
	logic [7:0] next_cpu_rdata;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// one byte register per offset
	assign wr_sel = gpp_decode(cpu_addr);
	assign rd_sel = gpp_decode(cpu_addr);
	assign wr_hit = cpu_wr && (wr_sel != GPP_SEL_NONE);

	// ----------------------------------------
	// Pin level input
	// ----------------------------------------
	// two-flop synchroniser on pins
	gpp_sync #(
		.WIDTH    (GPP_DATA_W)
	) u_sync (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.signal_line_a_in (pad_in),
		.sync_out (pin_level_input)
	);

	// ----------------------------------------
	// Alternate function enable
	// ----------------------------------------
	// reset returns pins to GPIO
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			alt_function_enable <= GPP_RST_ALT_ENABLE;
		end
		else if (cpu_wr && wr_sel == GPP_SEL_ALT_ENABLE)
		begin
			alt_function_enable <= cpu_wdata;
		end
	end

	// ----------------------------------------
	// Alternate function choice
	// ----------------------------------------
	// bits without a second function are left as written
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			alt_function_choice <= GPP_RST_ALT_CHOICE;
		end
		else if (cpu_wr && wr_sel == GPP_SEL_ALT_CHOICE)
		begin
			alt_function_choice <= cpu_wdata;
		end
	end

	// ----------------------------------------
	// Direction
	// ----------------------------------------
	// reset makes all pins inputs
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_direction <= GPP_RST_DIRECTION;
		end
		else if (cpu_wr && wr_sel == GPP_SEL_DIRECTION)
		begin
			pin_direction <= cpu_wdata;
		end
	end

	// ----------------------------------------
	// Weak pull-up enable
	// ----------------------------------------
	// pull-ups cleared by reset
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pullup_enable <= GPP_RST_PULLUP;
		end
		else if (cpu_wr && wr_sel == GPP_SEL_PULLUP)
		begin
			pullup_enable <= cpu_wdata;
		end
	end

	// ----------------------------------------
	// Slew rate select
	// ----------------------------------------
	// reset leaves slow slew
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			slew_rate_select <= GPP_RST_SLEW;
		end
		else if (cpu_wr && wr_sel == GPP_SEL_SLEW)
		begin
			slew_rate_select <= cpu_wdata;
		end
	end

	// ----------------------------------------
	// Output data latch
	// ----------------------------------------
	// no reset term: value survives reset, unknown at power-up
	always_ff @(posedge mclk)
	begin
		if (cpu_wr && wr_sel == GPP_SEL_OUT_LATCH)
		begin
			output_data_latch <= cpu_wdata;
		end
	end

	// ----------------------------------------
	// Pin routing
	// ----------------------------------------
	// peripheral set per port chosen by masks
	gpp_altmux #(
		.ALT0_MASK  (ALT0_MASK),
		.ALT1_MASK  (ALT1_MASK)
	) u_altmux (
		.alt_enable (alt_function_enable),
		.alt_choice (alt_function_choice),
		.direction  (pin_direction),
		.out_latch  (output_data_latch),
		.pu_enable  (pullup_enable),
		.pa_out     (periph_a_out),
		.pa_oe      (periph_a_oe),
		.pb_out     (periph_b_out),
		.pb_oe      (periph_b_oe),
		.level      (pin_level_input),
		.pin_out    (next_pad_out),
		.pin_oe     (next_pad_oe),
		.pin_pullup (next_pad_pullup),
		.pa_in      (next_periph_a_in),
		.pb_in      (next_periph_b_in)
	);

	// ----------------------------------------
	// Pad output registers
	// ----------------------------------------
	// latch value onto enabled buffer
	// Latch is unknown until written, so it is gated by the enable
	// here; a floating pin must not carry X into the pad ring.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pad_out <= '0;
			pad_oe  <= '0;
		end
		else
		begin
			pad_out <= next_pad_out & next_pad_oe;
			pad_oe  <= next_pad_oe;
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pad_pullup <= '0;
		end
		else
		begin
			pad_pullup <= next_pad_pullup;
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pad_fast <= '0;
		end
		else
		begin
			pad_fast <= slew_rate_select;
		end
	end

	// ----------------------------------------
	// Peripheral input registers
	// ----------------------------------------
	// only the chosen peripheral sees the pin
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			periph_a_in <= '0;
			periph_b_in <= '0;
		end
		else
		begin
			periph_a_in <= next_periph_a_in;
			periph_b_in <= next_periph_b_in;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb
	begin
		next_cpu_rdata = GPP_RDATA_IDLE;
		unique case (rd_sel)
			GPP_SEL_ALT_ENABLE:
			begin
				next_cpu_rdata = alt_function_enable;
			end
			GPP_SEL_ALT_CHOICE:
			begin
				next_cpu_rdata = alt_function_choice;
			end
			GPP_SEL_DIRECTION:
			begin
				next_cpu_rdata = pin_direction;
			end
			GPP_SEL_PIN_LEVEL:
			begin
				next_cpu_rdata = pin_level_input;
			end
			// last written value, not the pin
			GPP_SEL_OUT_LATCH:
			begin
				next_cpu_rdata = output_data_latch;
			end
			GPP_SEL_PULLUP:
			begin
				next_cpu_rdata = pullup_enable;
			end
			GPP_SEL_SLEW:
			begin
				next_cpu_rdata = slew_rate_select;
			end
			GPP_SEL_NONE:
			begin
				next_cpu_rdata = GPP_RDATA_IDLE;
			end
		endcase
	end

	// One cycle read latency; data held until the next read
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cpu_rdata  <= GPP_RDATA_IDLE;
			cpu_rvalid <= 1'b0;
		end
		else
		begin
			cpu_rvalid <= cpu_rd;
			if (cpu_rd)
			begin
				cpu_rdata <= next_cpu_rdata;
			end
		end
	end

	// ----------------------------------------
	// Write side notes
	// ----------------------------------------
	// writes to the level offset land nowhere
	// wr_hit is kept for readability of the decode only.
	logic unused_wr_hit;
	assign unused_wr_hit = wr_hit;

endmodule

// [rtl/gpp_pkg.sv]
// Shared constants for the byte-wide general-purpose port block.
// Assumes one byte-wide CPU register port per port instance.
package gpp_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int GPP_DATA_W = 8;
	localparam int GPP_ADDR_W = 4;
	localparam int GPP_SYNC_STAGES = 2;

	// ----------------------------------------
	// Register offsets within one port
	// ----------------------------------------
	localparam logic [3:0] GPP_OFS_ALT_ENABLE = 4'h0;
	localparam logic [3:0] GPP_OFS_DIRECTION  = 4'h2;
	localparam logic [3:0] GPP_OFS_PIN_LEVEL  = 4'h4;
	localparam logic [3:0] GPP_OFS_OUT_LATCH  = 4'h6;
	localparam logic [3:0] GPP_OFS_PULLUP     = 4'h8;
	localparam logic [3:0] GPP_OFS_SLEW       = 4'hA;
	localparam logic [3:0] GPP_OFS_ALT_CHOICE = 4'hC;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] GPP_RST_ALT_ENABLE = 8'h00;
	localparam logic [7:0] GPP_RST_DIRECTION  = 8'h00;
	localparam logic [7:0] GPP_RST_PULLUP     = 8'h00;
	localparam logic [7:0] GPP_RST_SLEW       = 8'h00;
	localparam logic [7:0] GPP_RST_ALT_CHOICE = 8'h00;
	localparam logic [7:0] GPP_RDATA_IDLE     = 8'h00;

	// Default masks of pins that have a first / second peripheral function
	localparam logic [7:0] GPP_DEF_ALT0_MASK  = 8'hFF;
	localparam logic [7:0] GPP_DEF_ALT1_MASK  = 8'hFF;

	// ----------------------------------------
	// Register selection
	// ----------------------------------------
	typedef enum {
		GPP_SEL_NONE,
		GPP_SEL_ALT_ENABLE,
		GPP_SEL_DIRECTION,
		GPP_SEL_PIN_LEVEL,
		GPP_SEL_OUT_LATCH,
		GPP_SEL_PULLUP,
		GPP_SEL_SLEW,
		GPP_SEL_ALT_CHOICE
	} gpp_sel_t;

	function automatic gpp_sel_t gpp_decode(input logic [3:0] addr);
		gpp_sel_t sel;
		sel = GPP_SEL_NONE;
		unique case (addr)
			GPP_OFS_ALT_ENABLE: sel = GPP_SEL_ALT_ENABLE;
			GPP_OFS_DIRECTION:  sel = GPP_SEL_DIRECTION;
			GPP_OFS_PIN_LEVEL:  sel = GPP_SEL_PIN_LEVEL;
			GPP_OFS_OUT_LATCH:  sel = GPP_SEL_OUT_LATCH;
			GPP_OFS_PULLUP:     sel = GPP_SEL_PULLUP;
			GPP_OFS_SLEW:       sel = GPP_SEL_SLEW;
			GPP_OFS_ALT_CHOICE: sel = GPP_SEL_ALT_CHOICE;
			default:            sel = GPP_SEL_NONE;
		endcase
		return sel;
	endfunction

endpackage

// [rtl/gpp_sync.sv]
// Two-flop synchroniser for a bus of independent pin levels.
// Assumes each bit is unrelated; no bus coherence is promised.
`timescale 1ns/1ps
module gpp_sync
	import gpp_pkg::*;
#(
	parameter int WIDTH = GPP_DATA_W
)
(
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             arst_n,
	// Levels
	input  wire logic [WIDTH-1:0] signal_line_a_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	// First stage feeds only the second stage
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stage1   <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1   <= signal_line_a_in;
			sync_out <= stage1;
		end
	end

endmodule

// [rtl/gpp_altmux.sv]
// Per-pin routing between general-purpose control and two peripherals.
// Purely combinational; the caller registers everything it drives out.
`timescale 1ns/1ps
module gpp_altmux
	import gpp_pkg::*;
#(
	parameter logic [7:0] ALT0_MASK = GPP_DEF_ALT0_MASK,
	parameter logic [7:0] ALT1_MASK = GPP_DEF_ALT1_MASK
)
(
	// Port configuration
	input  wire logic [7:0] alt_enable,
	input  wire logic [7:0] alt_choice,
	input  wire logic [7:0] direction,
	input  wire logic [7:0] out_latch,
	input  wire logic [7:0] pu_enable,
	// Peripheral drive
	input  wire logic [7:0] pa_out,
	input  wire logic [7:0] pa_oe,
	input  wire logic [7:0] pb_out,
	input  wire logic [7:0] pb_oe,
	// Pin level
	input  wire logic [7:0] level,
	// Results
	output logic      [7:0] pin_out,
	output logic      [7:0] pin_oe,
	output logic      [7:0] pin_pullup,
	output logic      [7:0] pa_in,
	output logic      [7:0] pb_in
);

	logic [7:0] use_a;
	logic [7:0] use_b;

	// choice only matters when enabled; reserved connects nothing
	assign use_a = alt_enable & ~alt_choice & ALT0_MASK;
	assign use_b = alt_enable & alt_choice & ALT1_MASK;

	// peripheral owns the pin in alternate mode
	assign pin_out = (~alt_enable & out_latch) | (use_a & pa_out) | (use_b & pb_out);
	assign pin_oe  = (~alt_enable & direction) | (use_a & pa_oe) | (use_b & pb_oe);

	// pull-up only in GPIO mode with buffer off
	assign pin_pullup = ~alt_enable & pu_enable & ~direction;

	// unselected peripheral sees a quiet low
	assign pa_in = use_a & level;
	assign pb_in = use_b & level;

endmodule

// [verif/gpp_port_chk.sv]
// Checker for gpp_port, watching its register and pad ports.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/1ps
module gpp_port_chk
	import gpp_pkg::*;
(
	// Clock and reset
	input wire logic       mclk,
	input wire logic       arst_n,
	// Register port
	input wire logic [3:0] cpu_addr,
	input wire logic       cpu_wr,
	input wire logic       cpu_rd,
	input wire logic [7:0] cpu_wdata,
	input wire logic [7:0] cpu_rdata,
	input wire logic       cpu_rvalid,
	// Pads
	input wire logic [7:0] pad_in,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pad_pullup,
	input wire logic [7:0] pad_fast
);
	// Synchroniser is only full a few edges after reset
	logic [1:0] age;
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
			age <= 2'h0;
		else if (age != 2'h3)
			age <= age + 2'h1;

	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	sequence latch_wr;
		cpu_wr && cpu_addr == GPP_OFS_OUT_LATCH;
	endsequence
	sequence latch_rd;
		cpu_rd && !cpu_wr && cpu_addr == GPP_OFS_OUT_LATCH;
	endsequence
	sequence pin_rd;
		cpu_rd && cpu_addr == GPP_OFS_PIN_LEVEL;
	endsequence

	rvalid_pulse_a: assert property (1 |=> cpu_rvalid == $past(cpu_rd))
		else $error("read valid not one cycle after read");
	rdata_hold_a: assert property (!cpu_rd |=> $stable(cpu_rdata))
		else $error("read data moved without a read");
	pin_read_a: assert property (age == 2'h3 && $stable(pad_in) ##1 $stable(pad_in) ##0 pin_rd
		|=> cpu_rdata == $past(pad_in))
		else $error("pin level read differs from steady pins");
	latch_readback_a: assert property (latch_wr ##1 latch_rd |=> cpu_rdata == $past(cpu_wdata, 2))
		else $error("output latch read not last written");
	slew_write_a: assert property (cpu_wr && cpu_addr == GPP_OFS_SLEW |-> ##2 pad_fast == $past(cpu_wdata, 2))
		else $error("slew pads do not follow write");
	oe_gate_a: assert property ((pad_out & ~pad_oe) == 8'h00)
		else $error("pad driven while buffer off");
	pullup_driven_a: assert property ((pad_pullup & pad_oe) == 8'h00)
		else $error("pull-up on a driven pad");
	unmapped_read_a: assert property (cpu_rd && (cpu_addr[0] || cpu_addr > 4'hC) |=> cpu_rdata == 8'h00)
		else $error("unmapped read not zero");
	reset_clear_a: assert property ($rose(arst_n) |-> ##1 (pad_oe | pad_pullup | pad_fast) == 8'h00)
		else $error("pad controls not cleared by reset");
endmodule

bind gpp_port gpp_port_chk u_gpp_port_chk (.mclk, .arst_n, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
	.cpu_rdata, .cpu_rvalid, .pad_in, .pad_out, .pad_oe, .pad_pullup, .pad_fast);

// [verif/gpp_pad_model.sv]
// Pin-side model: pads resolved against an external driver.
// Assumes the bench never drives a pin the port also drives.
`timescale 1ns/1ps
module gpp_pad_model
(
	// Clock
	input  wire logic       mclk,
	// Pad controls and external drive
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe,
	input  wire logic [7:0] pad_pullup,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	// Resolved level
	output logic      [7:0] pad_in
);
	// Floating pins wander so a stale level never reads as good
	logic [7:0] drift = 8'h55;
	logic [7:0] free;
	always_ff @(posedge mclk)
		drift <= ~drift;
	assign free = ~pad_oe & ~ext_en;
	// pull-up lifts only a released pin
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
		| (free & pad_pullup) | (free & ~pad_pullup & drift);
endmodule

// [verif/gpp_port_test.sv]
// Self-checking bench for gpp_port with a pad model on the pins.
// Assumes default masks: every pin has both peripheral functions.
`timescale 1ns/1ps
module gpp_port_test;
	import gpp_pkg::*;
	logic       mclk, arst_n, cpu_wr, cpu_rd, cpu_rvalid;
	logic [3:0] cpu_addr;
	logic [7:0] cpu_wdata, cpu_rdata, pad_in, pad_out, pad_oe, pad_pullup, pad_fast;
	logic [7:0] periph_a_out, periph_a_oe, periph_a_in, periph_b_out, periph_b_oe, periph_b_in;
	logic [7:0] ext_en, ext_val;
	int         err_count, n_compared;
	logic [3:0] rw_ofs[5] = '{GPP_OFS_ALT_ENABLE, GPP_OFS_DIRECTION, GPP_OFS_PULLUP, GPP_OFS_SLEW,
		GPP_OFS_ALT_CHOICE};

	gpp_port u_gpp_port (.mclk, .arst_n, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata,
		.cpu_rvalid, .pad_in, .pad_out, .pad_oe, .pad_pullup, .pad_fast, .periph_a_out,
		.periph_a_oe, .periph_a_in, .periph_b_out, .periph_b_oe, .periph_b_in);
	gpp_pad_model u_gpp_pad_model (.mclk, .pad_out, .pad_oe, .pad_pullup, .ext_en, .ext_val, .pad_in);

	task automatic wrap_up();
		if (err_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic idle(input int k);
		repeat (k) @(negedge mclk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge mclk);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr = 1'b1;
		@(negedge mclk);
		cpu_wr = 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		int n;
		@(negedge mclk);
		cpu_addr = a;
		cpu_rd = 1'b1;
		@(negedge mclk);
		cpu_rd = 1'b0;
		n = 0;
		while (cpu_rvalid !== 1'b1 && n < 4)
		begin
			@(negedge mclk);
			n++;
		end
		chk({7'h00, cpu_rvalid}, 8'h01);
		chk(cpu_rdata, exp);
	endtask

	// Write then read in the very next cycle
	task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
		@(negedge mclk);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr = 1'b1;
		@(negedge mclk);
		cpu_wr = 1'b0;
		cpu_rd = 1'b1;
		@(negedge mclk);
		cpu_rd = 1'b0;
		chk(cpu_rdata, d);
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Whole sequence needs about 130 cycles
	initial
	begin
		#100000;
		err_count++;
		wrap_up();
	end

	initial
	begin
		{arst_n, cpu_wr, cpu_rd, cpu_addr, cpu_wdata, ext_en, ext_val} = '0;
		{periph_a_out, periph_a_oe, periph_b_out, periph_b_oe} = '0;
		err_count = 0;
		n_compared = 0;
		idle(3);
		arst_n = 1'b1;
		foreach (rw_ofs[i])
		begin
			rd(rw_ofs[i], 8'h00);
			wr(rw_ofs[i], 8'hA5);
			rd(rw_ofs[i], 8'hA5);
			wr(rw_ofs[i], 8'h00);
		end
		wr_rd(GPP_OFS_OUT_LATCH, 8'hC9);
		wr(GPP_OFS_OUT_LATCH, 8'h5A);
		rd(GPP_OFS_OUT_LATCH, 8'h5A);
		wr(GPP_OFS_DIRECTION, 8'hFF);
		idle(2);
		chk(pad_oe, 8'hFF);
		chk(pad_out, 8'h5A);
		idle(3);
		rd(GPP_OFS_PIN_LEVEL, 8'h5A);
		wr(GPP_OFS_PIN_LEVEL, 8'h00);
		rd(GPP_OFS_PIN_LEVEL, 8'h5A);
		rd(4'h3, 8'h00);
		wr(GPP_OFS_DIRECTION, 8'h0F);
		wr(GPP_OFS_PULLUP, 8'hFF);
		idle(4);
		chk(pad_pullup, 8'hF0);
		rd(GPP_OFS_PIN_LEVEL, 8'hFA);
		// open drain: clear latch, then steer by direction
		wr(GPP_OFS_OUT_LATCH, 8'h00);
		wr(GPP_OFS_DIRECTION, 8'h01);
		idle(4);
		rd(GPP_OFS_PIN_LEVEL, 8'hFE);
		wr(GPP_OFS_DIRECTION, 8'h00);
		idle(4);
		rd(GPP_OFS_PIN_LEVEL, 8'hFF);
		wr(GPP_OFS_PULLUP, 8'h00);
		ext_en = 8'hFF;
		ext_val = 8'hC3;
		idle(4);
		rd(GPP_OFS_PIN_LEVEL, 8'hC3);
		ext_en = 8'h00;
		wr(GPP_OFS_SLEW, 8'hFF);
		idle(2);
		chk(pad_fast, 8'hFF);
		wr(GPP_OFS_OUT_LATCH, 8'h96);
		// Inputs in GPIO terms, so only alternate mode keeps pull-ups off
		wr(GPP_OFS_DIRECTION, 8'h00);
		{periph_a_out, periph_a_oe, periph_b_out, periph_b_oe} = {8'h33, 8'hFF, 8'hCC, 8'hFF};
		// every pin here has a second function
		wr(GPP_OFS_ALT_CHOICE, 8'h0F);
		wr(GPP_OFS_PULLUP, 8'hFF);
		wr(GPP_OFS_ALT_ENABLE, 8'hFF);
		idle(4);
		chk(pad_out, 8'h3C);
		chk(pad_pullup, 8'h00);
		chk(pad_oe, 8'hFF);
		chk(pad_fast, 8'hFF);
		chk(periph_a_in, 8'h30);
		chk(periph_b_in, 8'h0C);
		wr(GPP_OFS_DIRECTION, 8'hFF);
		wr(GPP_OFS_ALT_ENABLE, 8'h00);
		idle(2);
		chk(pad_out, 8'h96);
		arst_n = 1'b0;
		idle(3);
		arst_n = 1'b1;
		rd(GPP_OFS_OUT_LATCH, 8'h96);
		rd(GPP_OFS_DIRECTION, 8'h00);
		chk(pad_fast, 8'h00);
		wrap_up();
	end
endmodule
